// ### hw/tisc_top.v
// input select control of the tmds regenerator with its register file
`include "tisc_defs.vh"
module tisc_top (
  input wire ref_clk_i,
  input wire reset_n_i,
  // register port, as the serial interface delivers it
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // pins, all asynchronous
  input wire auto_pick_pin_i,
  // select pins are only ever read; nothing in here drives them
  input wire [1:0] chan_pick_pins_i,
  input wire powerdown_pin_i,
  input wire [3:0] clk_toggle_act_i,
  input wire [3:0] clk_cm_high_i,
  // routing and analog settings
  output reg [1:0] route_sel_o,
  output reg route_active_o,
  output reg tmds_out_en_o,
  output reg tmds_in_conn_o,
  output reg [1:0] clk_offset_o,
  output reg recal_pulse_o,
  output reg [15:0] eq_gain_o,
  output reg [3:0] preemph_data_o,
  output reg [3:0] preemph_clk_o,
  output reg [1:0] pll_bw_o,
  output reg relock_o,
  output reg [5:0] lane_rd_ptr_o,
  output reg powered_down_o
);
  // synchronised pins
  wire [3:0] tog_s;
  wire [3:0] cm_s;
  wire auto_s;
  wire [1:0] pick_s;
  wire pd_s;
  // register storage
  reg [7:0] chan_ctrl_reg;
  reg [7:0] act_cfg_reg;
  reg [7:0] out_drive_reg;
  reg [7:0] eq_ab_reg;
  reg [7:0] eq_cd_reg;
  reg [7:0] pll_bw_reg;
  // routing state
  reg [1:0] sel_reg;
  reg [1:0] sel_next;
  reg act_reg;
  reg act_next;
  // relock sequencing
  reg [7:0] lock_cnt_reg;
  reg pd_prev_reg;
  reg [1:0] skew_seed_reg;
  // working terms
  reg [3:0] act_vec;
  reg use_auto;
  reg [1:0] man_sel;
  reg [2:0] prio;
  wire pd_all;
  wire wr_cc;
  wire change;

  // all pin inputs through two flip-flops
  tisc_sync2 #(.W(12)) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({tog_s_raw_dummy_free(clk_toggle_act_i), clk_cm_high_i, auto_pick_pin_i,
      chan_pick_pins_i, powerdown_pin_i}),
    .sync_o({tog_s, cm_s, auto_s, pick_s, pd_s})
  );

  // identity helper keeps the concatenation readable
  function [3:0] tog_s_raw_dummy_free;
    input [3:0] v;
    begin
      tog_s_raw_dummy_free = v;
    end
  endfunction

  // priority encoder, bit 2 flags any active
  function [2:0] prio_pick;
    input [3:0] a;
    begin
      if (a[0])
        prio_pick = 3'h4;
      else if (a[1])
        prio_pick = 3'h5;
      else if (a[2])
        prio_pick = 3'h6;
      else if (a[3])
        prio_pick = 3'h7;
      else
        prio_pick = 3'h0;
    end
  endfunction

  assign pd_all = chan_ctrl_reg[`TISC_CC_PD] | pd_s;
  assign wr_cc = reg_wr_i && (reg_addr_i == `TISC_OFF_CHAN_CTRL);

  // activity source and selection mode
  always @*
  begin
    // method bit: one = common mode, zero = toggle sensing
    if (act_cfg_reg[`TISC_AC_METHOD])
      act_vec = ~cm_s;
    else
      act_vec = tog_s;
    // pins in charge until the hardware-select bit is cleared
    if (chan_ctrl_reg[`TISC_CC_HWSEL])
    begin
      use_auto = auto_s;
      man_sel = pick_s;
    end
    else
    begin
      use_auto = chan_ctrl_reg[`TISC_CC_AUTO];
      man_sel = chan_ctrl_reg[`TISC_CC_SEL_HI:`TISC_CC_SEL_LO];
    end
    prio = prio_pick(act_vec);
    // auto: lowest-numbered active, manual: coded channel always forwarded
    if (use_auto)
    begin
      sel_next = prio[1:0];
      act_next = prio[2];
    end
    else
    begin
      sel_next = man_sel;
      act_next = 1'b1;
    end
  end

  assign change = (sel_next != sel_reg) || (act_next && !act_reg);

  // routed channel register
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sel_reg <= 2'h0;
      act_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= sel_next;
      act_reg <= act_next & ~pd_all;
    end
  end

  // register writes; the port works regardless of powerdown
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      chan_ctrl_reg <= `TISC_RST_CHAN_CTRL;
      act_cfg_reg <= `TISC_RST_ACT_CFG;
      out_drive_reg <= `TISC_RST_OUT_DRIVE;
      eq_ab_reg <= `TISC_RST_EQ;
      eq_cd_reg <= `TISC_RST_EQ;
      pll_bw_reg <= `TISC_RST_PLL_BW;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `TISC_OFF_CHAN_CTRL:
        begin
          // select bits only writable in register manual mode
          if (!reg_wdata_i[`TISC_CC_HWSEL] && !reg_wdata_i[`TISC_CC_AUTO])
            chan_ctrl_reg <= reg_wdata_i;
          else
            chan_ctrl_reg <= {reg_wdata_i[`TISC_CC_UP_HI:`TISC_CC_UP_LO],
              chan_ctrl_reg[`TISC_CC_SEL_HI:`TISC_CC_SEL_LO]};
        end
        // activity method, clock offset and recal strobe bit
        `TISC_OFF_ACT_CFG:
          act_cfg_reg <= reg_wdata_i;
        // pre-emphasis nibble sits in the upper half
        `TISC_OFF_OUT_DRIVE:
          out_drive_reg <= reg_wdata_i;
        // two gain nibbles per equalizer register
        `TISC_OFF_EQ_AB:
          eq_ab_reg <= reg_wdata_i;
        `TISC_OFF_EQ_CD:
          eq_cd_reg <= reg_wdata_i;
        // bandwidth code in the low bits, upper bits kept as written
        `TISC_OFF_PLL_BW:
          pll_bw_reg <= reg_wdata_i;
        // unmapped offsets leave every register alone
        default:
          chan_ctrl_reg <= chan_ctrl_reg;
      endcase
    end
  end

  // read mux; select bits show routed channel in auto modes
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `TISC_OFF_CHAN_CTRL:
          begin
            if (use_auto)
              reg_rdata_o <= {chan_ctrl_reg[`TISC_CC_UP_HI:`TISC_CC_UP_LO],
                sel_reg};
            // manual modes show the code that is in charge
            else
              reg_rdata_o <= {chan_ctrl_reg[`TISC_CC_UP_HI:`TISC_CC_UP_LO],
                man_sel};
          end
          `TISC_OFF_ACT_CFG:
            reg_rdata_o <= act_cfg_reg;
          `TISC_OFF_OUT_DRIVE:
            reg_rdata_o <= out_drive_reg;
          `TISC_OFF_EQ_AB:
            reg_rdata_o <= eq_ab_reg;
          `TISC_OFF_EQ_CD:
            reg_rdata_o <= eq_cd_reg;
          `TISC_OFF_PLL_BW:
            reg_rdata_o <= pll_bw_reg;
          // unmapped offsets read as zero
          default:
            reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // relock and lane pointer placement after each discontinuity
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lock_cnt_reg <= `TISC_RELOCK_CYC;
      pd_prev_reg <= 1'b0;
      skew_seed_reg <= 2'h0;
      lane_rd_ptr_o <= 6'h00;
      relock_o <= 1'b1;
    end
    else
    begin
      pd_prev_reg <= pd_all;
      // free-running seed gives a random pointer offset
      if (skew_seed_reg == `TISC_SKEW_MAX)
        skew_seed_reg <= 2'h0;
      else
        skew_seed_reg <= skew_seed_reg + 2'h1;
      // powerdown entry and exit both count as discontinuities
      if (change || pd_all || pd_prev_reg)
      begin
        lock_cnt_reg <= `TISC_RELOCK_CYC;
        relock_o <= 1'b1;
      end
      else if (lock_cnt_reg != 8'h00)
      begin
        // count down the lock wait
        lock_cnt_reg <= lock_cnt_reg - 8'h01;
        if (lock_cnt_reg == 8'h01)
        begin
          // lane 0 at zero, others within two bits, fixed until next change
          lane_rd_ptr_o <= {skew_seed_reg, skew_seed_reg[0], 1'b0, 2'h0};
          relock_o <= 1'b0;
        end
      end
    end
  end

  // registered analog settings and routing outputs
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      route_sel_o <= 2'h0;
      route_active_o <= 1'b0;
      tmds_out_en_o <= 1'b0;
      tmds_in_conn_o <= 1'b0;
      clk_offset_o <= 2'h0;
      recal_pulse_o <= 1'b0;
      eq_gain_o <= {`TISC_RST_EQ, `TISC_RST_EQ};
      preemph_data_o <= 4'h0;
      preemph_clk_o <= 4'h0;
      pll_bw_o <= 2'h0;
      powered_down_o <= 1'b0;
    end
    else
    begin
      route_sel_o <= sel_reg;
      route_active_o <= act_reg & ~relock_o;
      tmds_out_en_o <= ~pd_all;
      tmds_in_conn_o <= ~pd_all;
      powered_down_o <= pd_all;
      clk_offset_o <= act_cfg_reg[`TISC_AC_OFS_HI:`TISC_AC_OFS_LO];
      // one-cycle strobe for each recal write
      recal_pulse_o <= wr_cc ? 1'b0 : (reg_wr_i && (reg_addr_i == `TISC_OFF_ACT_CFG)
        && reg_wdata_i[`TISC_AC_RECAL]);
      eq_gain_o <= {eq_cd_reg, eq_ab_reg};
      preemph_data_o <= out_drive_reg[`TISC_OD_PRE_HI:`TISC_OD_PRE_LO];
      // the clock lane never gets any boost
      preemph_clk_o <= 4'h0;
      pll_bw_o <= pll_bw_reg[`TISC_PLL_BW_HI:`TISC_PLL_BW_LO];
    end
  end
endmodule

// ### hw/tisc_defs.vh
// register map, field positions and reset values of the input select control
`ifndef TISC_DEFS_VH
`define TISC_DEFS_VH
`define TISC_ADDR_W 8
`define TISC_OFF_CHAN_CTRL 8'h02
`define TISC_OFF_ACT_CFG 8'h03
`define TISC_OFF_OUT_DRIVE 8'h06
`define TISC_OFF_EQ_AB 8'h07
`define TISC_OFF_EQ_CD 8'h08
`define TISC_OFF_PLL_BW 8'h10
`define TISC_CC_SEL_LO 0
`define TISC_CC_SEL_HI 1
`define TISC_CC_AUTO 2
`define TISC_CC_HWSEL 3
`define TISC_CC_PD 5
`define TISC_AC_METHOD 4
`define TISC_AC_OFS_LO 5
`define TISC_AC_OFS_HI 6
`define TISC_AC_RECAL 7
`define TISC_RST_CHAN_CTRL 8'h08
`define TISC_RST_ACT_CFG 8'h10
`define TISC_RST_OUT_DRIVE 8'h00
`define TISC_RST_EQ 8'hCC
`define TISC_RST_PLL_BW 8'h10
`define TISC_SEL_W 2
`define TISC_NCH 4
`define TISC_RELOCK_CYC 8'h40
`define TISC_SKEW_MAX 2'h2
`define TISC_CC_UP_HI 7
`define TISC_CC_UP_LO 2
`define TISC_OD_PRE_HI 7
`define TISC_OD_PRE_LO 4
`define TISC_PLL_BW_HI 1
`define TISC_PLL_BW_LO 0
`endif

// ### hw/tisc_sync2.v
// two flip-flop synchroniser for a vector of level inputs
module tisc_sync2 #(
  parameter W = 4
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  // first stage, read only by the second stage
  reg [W-1:0] meta_reg;
  // second stage, safe to use
  reg [W-1:0] stable_reg;
  // shift the raw level through two stages
  always @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_reg <= {W{1'b0}};
      stable_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= async_i;
      stable_reg <= meta_reg;
    end
  end
  assign sync_o = stable_reg;
endmodule

// ### tb/tisc_src_model.sv
// behavioural model of the four video sources at the clock inputs
module tisc_src_model (
  input wire logic [3:0] live_i,
  input wire logic cm_stuck_i,
  output logic [3:0] toggle_o,
  output logic [3:0] cm_high_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a live source toggles its clock pair
  assign toggle_o = live_i;
  // absent source leaves common mode at supply; stuck low mimics weak drive
  assign cm_high_o = cm_stuck_i ? 4'h0 : ~live_i;
endmodule

// ### tb/tisc_top_sva.sv
// port assertions of the input select control
module tisc_top_sva (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire powerdown_pin_i,
  input wire powered_down_o,
  input wire tmds_out_en_o,
  input wire tmds_in_conn_o,
  input wire [3:0] preemph_clk_o,
  input wire [1:0] route_sel_o,
  input wire relock_o,
  input wire route_active_o,
  input wire [5:0] lane_rd_ptr_o,
  input wire recal_pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // lane pointers and whether any sits at either extreme
  wire [1:0] lane0 = lane_rd_ptr_o[1:0];
  wire [1:0] lane1 = lane_rd_ptr_o[3:2];
  wire [1:0] lane2 = lane_rd_ptr_o[5:4];
  wire any_top = (lane0 == 2'h3) || (lane1 == 2'h3) || (lane2 == 2'h3);
  wire any_bottom = (lane0 == 2'h0) || (lane1 == 2'h0) || (lane2 == 2'h0);
  // pin held long enough to pass the synchroniser
  sequence s_pd_held;
    powerdown_pin_i [*5];
  endsequence
  AST_PD_PIN: assert property (s_pd_held |-> powered_down_o)
    else $error("powerdown pin ignored");
  AST_PD_OFF: assert property (powered_down_o [*2] |-> !tmds_out_en_o && !tmds_in_conn_o)
    else $error("tmds alive in powerdown");
  AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  AST_RD_QUIET: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("stray read valid");
  AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  AST_CLK_NO_PREEMPH: assert property (preemph_clk_o == 4'h0)
    else $error("clock lane boosted");
  AST_RELOCK_ON_MOVE: assert property ($changed(route_sel_o) |-> ##[0:1] relock_o)
    else $error("route moved without relock");
  AST_LOCK_BEFORE_ACTIVE: assert property ($rose(route_active_o) |-> !$past(relock_o))
    else $error("active before lock");
  AST_LANE_SPREAD: assert property (!(any_top && any_bottom))
    else $error("lane pointers more than two apart");
  AST_LANE_FIXED: assert property (route_active_o |-> $stable(lane_rd_ptr_o))
    else $error("lane skew moved while locked");
  AST_RECAL_ONE: assert property (recal_pulse_o |=> !recal_pulse_o)
    else $error("recal pulse too long");
endmodule

// ### tb/test_tisc_top.sv
// self-checking bench of the input select control
module test_tisc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic auto_pick_pin_i = 0, powerdown_pin_i = 0, cm_stuck = 0;
  logic [5:0] lane_hold;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, rd_d;
  logic [1:0] chan_pick_pins_i = 0;
  logic [3:0] live = 0;
  wire [3:0] clk_toggle_act_i, clk_cm_high_i, preemph_data_o, preemph_clk_o;
  wire [7:0] reg_rdata_o;
  wire [15:0] eq_gain_o;
  wire [5:0] lane_rd_ptr_o;
  wire [1:0] route_sel_o, clk_offset_o, pll_bw_o;
  wire reg_rvalid_o, route_active_o, tmds_out_en_o, tmds_in_conn_o;
  wire recal_pulse_o, relock_o, powered_down_o;
  int fail_count = 0, checks = 0, recal_seen = 0;
  // reset-value table: offset and expected byte, last one unmapped
  logic [7:0] ra [7] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h10, 8'h05};
  logic [7:0] rv [7] = '{8'h08, 8'h10, 8'h00, 8'hcc, 8'hcc, 8'h10, 8'h00};
  // activity masks and the channel that wins
  logic [3:0] lv [4] = '{4'hf, 4'he, 4'hc, 4'h8};
  tisc_top i_dut (.ref_clk_i, .reset_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .auto_pick_pin_i, .chan_pick_pins_i, .powerdown_pin_i,
    .clk_toggle_act_i, .clk_cm_high_i, .route_sel_o, .route_active_o, .tmds_out_en_o,
    .tmds_in_conn_o, .clk_offset_o, .recal_pulse_o, .eq_gain_o, .preemph_data_o,
    .preemph_clk_o, .pll_bw_o, .relock_o, .lane_rd_ptr_o, .powered_down_o);
  tisc_src_model i_src (.live_i(live), .cm_stuck_i(cm_stuck), .toggle_o(clk_toggle_act_i),
    .cm_high_o(clk_cm_high_i));
  // 25 mhz clock
  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // count recalibration pulses
  always @(posedge ref_clk_i)
    if (recal_pulse_o === 1'b1)
      recal_seen++;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_d = reg_rdata_o;
  endtask
  // wait past sync and the 64-cycle relock
  task automatic settle(input int n = 80);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd(ra[i]);
      chk("reset value", rv[i], rd_d);
    end
    chan_pick_pins_i <= 2'h2;
    settle();
    chk("pin route", 3'h6, {route_active_o, route_sel_o});
    lane_hold = lane_rd_ptr_o;
    settle(20);
    chk("lane hold", lane_hold, lane_rd_ptr_o);
    $display("test reset and pins done");
    auto_pick_pin_i <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      live <= lv[i];
      settle();
      chk("auto route", i[1:0], route_sel_o);
      rd(8'h02);
      chk("auto index", i[1:0], rd_d[1:0]);
    end
    live <= 4'h0;
    settle();
    chk("none active", 1'b0, route_active_o);
    live <= 4'h8;
    cm_stuck <= 1'b1;
    settle();
    chk("common mode", 2'h0, route_sel_o);
    wr(8'h03, 8'h00);
    settle();
    chk("toggle detect", 2'h3, route_sel_o);
    cm_stuck <= 1'b0;
    $display("test auto done");
    wr(8'h02, 8'h01);
    settle();
    chk("reg manual", 2'h1, route_sel_o);
    rd(8'h02);
    chk("reg manual read", 8'h01, rd_d);
    wr(8'h02, 8'h06);
    settle();
    chk("reg auto", 2'h3, route_sel_o);
    rd(8'h02);
    chk("reg auto read", 8'h07, rd_d);
    $display("test register select done");
    wr(8'h03, 8'he0);
    wr(8'h06, 8'hf5);
    wr(8'h07, 8'ha5);
    wr(8'h08, 8'h3c);
    settle(3);
    chk("offset", 2'h3, clk_offset_o);
    chk("recal", 16'h1, recal_seen[15:0]);
    chk("preemph", 4'hf, preemph_data_o);
    chk("eq gain", 16'h3ca5, eq_gain_o);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h10, {6'h04, i[1:0]});
      settle(3);
      chk("pll bw", i[1:0], pll_bw_o);
    end
    $display("test settings done");
    wr(8'h02, 8'h21);
    settle(3);
    chk("pd bit", 2'h0, {tmds_out_en_o, tmds_in_conn_o});
    rd(8'h07);
    chk("read in pd", 8'ha5, rd_d);
    wr(8'h07, 8'haa);
    wr(8'h08, 8'haa);
    settle(3);
    chk("eq fixed", 16'haaaa, eq_gain_o);
    wr(8'h02, 8'h01);
    wr(8'h03, 8'h80);
    settle();
    chk("pd exit", 2'h3, {tmds_out_en_o, tmds_in_conn_o});
    powerdown_pin_i <= 1'b1;
    settle(6);
    chk("pd pin", 2'h0, {tmds_out_en_o, tmds_in_conn_o});
    powerdown_pin_i <= 1'b0;
    $display("test powerdown done");
    print_verdict();
  end
endmodule
bind tisc_top tisc_top_sva i_sva (.ref_clk_i, .reset_n_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .powerdown_pin_i, .powered_down_o, .tmds_out_en_o, .tmds_in_conn_o,
  .preemph_clk_o, .route_sel_o, .relock_o, .route_active_o, .lane_rd_ptr_o, .recal_pulse_o);
